//--- shared/ssr_cfg.svh
// Constants for the sensor status word block
`ifndef SSR_CFG_SVH
`define SSR_CFG_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define SSR_CMD_CLEAR     16'h3041  // Clear sticky status flags

// ----------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------
`define SSR_STATUS_W      16        // Width of the status word
`define SSR_BIT_ALERT     15        // Alert pending
`define SSR_BIT_HEATER    13        // Heater on
`define SSR_BIT_TRACK     10        // Temperature tracking alert
`define SSR_BIT_RESET     4         // System reset detected
`define SSR_BIT_CMD_ERR   1         // Last command not processed
`define SSR_BIT_CRC_ERR   0         // Last write checksum failed

// ----------------------------------------------------------------
// Reset values of the flags
// ----------------------------------------------------------------
`define SSR_RST_ALERT     1'h1      // Alert pending after reset
`define SSR_RST_TRACK     1'h0      // No tracking alert after reset
`define SSR_RST_RESET     1'h1      // Reset detected after reset
`define SSR_RST_CMD_ERR   1'h0      // Command status after reset
`define SSR_RST_CRC_ERR   1'h0      // Checksum status after reset
`define SSR_RST_HEATER    1'h0      // Heater shown off after reset

// ----------------------------------------------------------------
// Checksum parameters
// ----------------------------------------------------------------
`define SSR_CRC_POLY      8'h31     // x^8 + x^5 + x^4 + 1
`define SSR_CRC_INIT      8'hff     // Start value of the checksum
`define SSR_CRC_GOOD      8'h00     // Residue over data plus checksum

`endif

//--- shared/ssr_pkg.sv
// Types and checksum function for the sensor status word block
`include "ssr_cfg.svh"

package ssr_pkg;

  // --------------------------------------------------------------
  // Status word as seen by the bus controller
  // --------------------------------------------------------------
  typedef struct packed {
    logic       alert;     // At least one alert pending
    logic       rsvd14;    // Reads zero
    logic       heater;    // Heater on
    logic [1:0] rsvd12;    // Reads zero
    logic       track;     // Tracking alert
    logic [4:0] rsvd9;     // Undefined, driven zero
    logic       reset;     // Reset detected
    logic [1:0] rsvd3;     // Reads zero
    logic       cmd_err;   // Last command not processed
    logic       crc_err;   // Last write checksum failed
  } ssr_status_t;

  // --------------------------------------------------------------
  // Command handed on to the rest of the sensor
  // --------------------------------------------------------------
  typedef struct packed {
    logic [15:0] code;     // Command code
    logic        has_data; // Data word came with it
    logic [15:0] data;     // Checked data word
  } ssr_cmd_t;

  // --------------------------------------------------------------
  // Receive position inside one write transfer
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    RX_CMD_HI,
    RX_CMD_LO,
    RX_DAT_HI,
    RX_DAT_LO,
    RX_CRC,
    RX_FULL,
    RX_OVER
  } ssr_rx_state_t;

  // --------------------------------------------------------------
  // One byte of the CRC-8, MSB first, no reflection
  // --------------------------------------------------------------
  function automatic logic [7:0] ssr_crc8_byte(input logic [7:0] crc,
                                               input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `SSR_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction : ssr_crc8_byte

endpackage : ssr_pkg

//--- src/ssr_crc8.sv
// Running CRC-8 over the protected bytes of a write transfer
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_crc8 (
  input  wire logic       clk_sys_i,  // System clock
  input  wire logic       rst_n_i,    // Synchronous reset, active low
  input  wire logic       start_i,    // Restart at the init value
  input  wire logic       upd_i,      // Fold in one byte
  input  wire logic [7:0] byte_i,     // Byte to fold in
  output logic      [7:0] crc_o       // Current remainder
);

  // ----------------------------------------------------------------
  // Remainder register
  // ----------------------------------------------------------------
  logic [7:0] crc_d;  // Next remainder
  logic [7:0] crc_q;  // Current remainder

  // Restart wins over an update in the same cycle
  always_comb begin
    crc_d = crc_q;
    if (start_i) begin
      crc_d = `SSR_CRC_INIT;
    end else if (upd_i) begin
      crc_d = ssr_pkg::ssr_crc8_byte(crc_q, byte_i);
    end
  end

  // Register only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      crc_q <= `SSR_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule : ssr_crc8

//--- src/ssr_status.sv
// Sensor status word with its clear command and write checksum check
`timescale 1ns/1ps
`include "ssr_cfg.svh"

module ssr_status (
  input  wire logic              clk_sys_i,     // System clock
  input  wire logic              rst_n_i,       // Hard reset, active low
  // Write transfer bytes from the bus target front end
  input  wire logic              xfer_start_i,  // Write header taken
  input  wire logic              byte_vld_i,    // One write byte taken
  input  wire logic [7:0]        byte_i,        // Write byte
  input  wire logic              xfer_stop_i,   // Write transfer ended
  input  wire logic              cmd_known_i,   // Code is a known command
  // Events from the rest of the sensor
  input  wire logic              alert_pend_i,  // Some alert pending
  input  wire logic              track_alert_i, // Tracking alert event
  input  wire logic              soft_reset_i,  // Soft reset executed
  input  wire logic              supply_fail_i, // Supply failure seen
  input  wire logic              heater_on_i,   // Heater state
  // Results
  output ssr_pkg::ssr_status_t   status_o,      // Status word
  output logic                   cmd_vld_o,     // Command pulse
  output ssr_pkg::ssr_cmd_t      cmd_o          // Accepted command
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ssr_pkg::ssr_rx_state_t rx_d;        // Next receive position
  ssr_pkg::ssr_rx_state_t rx_q;        // Receive position
  logic [15:0]            code_d;      // Next command code
  logic [15:0]            code_q;      // Command code
  logic [15:0]            data_d;      // Next data word
  logic [15:0]            data_q;      // Data word
  logic                   crc_start;   // Restart the checksum
  logic                   crc_upd;     // Fold the byte in
  logic [7:0]             crc_rem;     // Checksum remainder

  logic                   alert_d;     // Next alert pending flag
  logic                   alert_q;     // Alert pending flag
  logic                   track_d;     // Next tracking alert flag
  logic                   track_q;     // Tracking alert flag
  logic                   rst_det_d;   // Next reset detected flag
  logic                   rst_det_q;   // Reset detected flag
  logic                   cmd_err_d;   // Next command status
  logic                   cmd_err_q;   // Command status
  logic                   crc_err_d;   // Next checksum status
  logic                   crc_err_q;   // Checksum status
  logic                   heater_d;    // Next heater bit

  logic                   end_cmd;     // Plain command ended
  logic                   end_data;    // Command with data ended
  logic                   end_bad;     // Malformed transfer ended
  logic                   crc_ok;      // Remainder shows a match
  logic                   do_clear;    // Clear command executes
  logic                   cmd_vld_d;   // Next command pulse
  logic                   cmd_vld_q;   // Command pulse
  ssr_pkg::ssr_cmd_t      cmd_d;       // Next command output
  ssr_pkg::ssr_cmd_t      cmd_q;       // Command output
  ssr_pkg::ssr_status_t   status_d;    // Next status word
  ssr_pkg::ssr_status_t   status_q;    // Status word

  // ----------------------------------------------------------------
  // Checksum over data bytes and the checksum byte
  // ----------------------------------------------------------------
  // Restart on the header, fold in bytes three to five
  assign crc_start = xfer_start_i;
  assign crc_upd   = byte_vld_i && !xfer_start_i &&
                     (rx_q == ssr_pkg::RX_DAT_HI ||
                      rx_q == ssr_pkg::RX_DAT_LO ||
                      rx_q == ssr_pkg::RX_CRC);

  ssr_crc8 u_crc (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .start_i   (crc_start),
    .upd_i     (crc_upd),
    .byte_i    (byte_i),
    .crc_o     (crc_rem)
  );

  // Data plus a matching checksum leaves a zero remainder
  assign crc_ok = (crc_rem == `SSR_CRC_GOOD);

  // ----------------------------------------------------------------
  // Byte collection inside one write transfer
  // ----------------------------------------------------------------
  // Next position and captured code and data
  always_comb begin
    rx_d   = rx_q;
    code_d = code_q;
    data_d = data_q;
    if (xfer_start_i) begin
      // New header restarts the count
      rx_d = ssr_pkg::RX_CMD_HI;
    end else if (byte_vld_i) begin
      unique case (rx_q)
        ssr_pkg::RX_CMD_HI: begin
          code_d[15:8] = byte_i;
          rx_d         = ssr_pkg::RX_CMD_LO;
        end
        ssr_pkg::RX_CMD_LO: begin
          code_d[7:0] = byte_i;
          rx_d        = ssr_pkg::RX_DAT_HI;
        end
        ssr_pkg::RX_DAT_HI: begin
          data_d[15:8] = byte_i;
          rx_d         = ssr_pkg::RX_DAT_LO;
        end
        ssr_pkg::RX_DAT_LO: begin
          data_d[7:0] = byte_i;
          rx_d        = ssr_pkg::RX_CRC;
        end
        ssr_pkg::RX_CRC: begin
          rx_d = ssr_pkg::RX_FULL;
        end
        ssr_pkg::RX_FULL,
        ssr_pkg::RX_OVER: begin
          // Excess bytes spoil the transfer
          rx_d = ssr_pkg::RX_OVER;
        end
        default: begin
          rx_d = ssr_pkg::RX_OVER;
        end
      endcase
    end
  end

  // Register only
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rx_q   <= ssr_pkg::RX_CMD_HI;
      code_q <= 16'h0000;
      data_q <= 16'h0000;
    end else begin
      rx_q   <= rx_d;
      code_q <= code_d;
      data_q <= data_d;
    end
  end

  // ----------------------------------------------------------------
  // End of transfer decode
  // ----------------------------------------------------------------
  // Stop with no bytes is ignored; a start in the same cycle wins
  assign end_cmd  = xfer_stop_i && !xfer_start_i &&
                    rx_q == ssr_pkg::RX_DAT_HI;
  assign end_data = xfer_stop_i && !xfer_start_i &&
                    rx_q == ssr_pkg::RX_FULL;
  assign end_bad  = xfer_stop_i && !xfer_start_i &&
                    (rx_q == ssr_pkg::RX_CMD_LO ||
                     rx_q == ssr_pkg::RX_DAT_LO ||
                     rx_q == ssr_pkg::RX_CRC    ||
                     rx_q == ssr_pkg::RX_OVER);
  // Clear takes no data word
  assign do_clear = end_cmd && code_q == `SSR_CMD_CLEAR;

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Sticky flags: a set in the clear cycle wins
  always_comb begin
    alert_d   = (alert_q && !do_clear) || alert_pend_i;
    track_d   = (track_q && !do_clear) || track_alert_i;
    rst_det_d = (rst_det_q && !do_clear) ||
                soft_reset_i || supply_fail_i;
    heater_d  = heater_on_i;
    cmd_err_d = cmd_err_q;
    crc_err_d = crc_err_q;
    if (end_cmd) begin
      // Plain command: known codes execute
      cmd_err_d = !(do_clear || cmd_known_i);
    end else if (end_data) begin
      // Data command needs a good checksum and a known code
      crc_err_d = !crc_ok;
      cmd_err_d = !(crc_ok && cmd_known_i);
    end else if (end_bad) begin
      // Wrong byte count cannot be processed
      cmd_err_d = 1'h1;
    end
  end

  // Register only; hard reset sets the reset flag
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      alert_q   <= `SSR_RST_ALERT;
      track_q   <= `SSR_RST_TRACK;
      rst_det_q <= `SSR_RST_RESET;
      cmd_err_q <= `SSR_RST_CMD_ERR;
      crc_err_q <= `SSR_RST_CRC_ERR;
    end else begin
      alert_q   <= alert_d;
      track_q   <= track_d;
      rst_det_q <= rst_det_d;
      cmd_err_q <= cmd_err_d;
      crc_err_q <= crc_err_d;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Status word from the flags; reserved bits zero
  always_comb begin
    status_d          = '0;
    status_d.alert    = alert_d;
    status_d.heater   = heater_d;
    status_d.track    = track_d;
    status_d.reset    = rst_det_d;
    status_d.cmd_err  = cmd_err_d;
    status_d.crc_err  = crc_err_d;
  end

  // Hand on commands other than clear that executed
  always_comb begin
    cmd_vld_d     = 1'h0;
    cmd_d         = cmd_q;
    if (end_cmd && !do_clear && cmd_known_i) begin
      cmd_vld_d     = 1'h1;
      cmd_d.code    = code_q;
      cmd_d.has_data = 1'h0;
      cmd_d.data    = 16'h0000;
    end else if (end_data && crc_ok && cmd_known_i) begin
      cmd_vld_d     = 1'h1;
      cmd_d.code    = code_q;
      cmd_d.has_data = 1'h1;
      cmd_d.data    = data_q;
    end
  end

  // Register only; status reset value matches the flag resets
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      status_q         <= '0;
      status_q.alert   <= `SSR_RST_ALERT;
      status_q.reset   <= `SSR_RST_RESET;
      status_q.heater  <= `SSR_RST_HEATER;
      cmd_vld_q        <= 1'h0;
      cmd_q            <= '0;
    end else begin
      status_q         <= status_d;
      cmd_vld_q        <= cmd_vld_d;
      cmd_q            <= cmd_d;
    end
  end

  assign status_o  = status_q;
  assign cmd_vld_o = cmd_vld_q;
  assign cmd_o     = cmd_q;

endmodule : ssr_status

//--- tb/ssr_status_properties.sv
// Concurrent checks on the ports of the sensor status word block
`timescale 1ns/1ps
module ssr_status_chk (
  input wire logic                 clk_sys_i,     // System clock
  input wire logic                 rst_n_i,       // Reset, active low
  input wire logic                 xfer_stop_i,   // Transfer end
  input wire logic                 alert_pend_i,  // Alert pending
  input wire logic                 track_alert_i, // Tracking alert
  input wire logic                 soft_reset_i,  // Soft reset
  input wire logic                 supply_fail_i, // Supply failure
  input wire logic                 heater_on_i,   // Heater state
  input wire ssr_pkg::ssr_status_t status_o,      // Status word
  input wire logic                 cmd_vld_o,     // Command pulse
  input wire ssr_pkg::ssr_cmd_t    cmd_o          // Command word
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_alert_set: assert property (alert_pend_i |=> status_o.alert)
    else $error("alert flag not set");
  a_reset_set: assert property (soft_reset_i || supply_fail_i
    |=> status_o.reset) else $error("reset flag not set");
  a_track_set: assert property (track_alert_i |=> status_o.track)
    else $error("tracking flag not set");
  a_rsvd_zero: assert property (status_o.rsvd14 == 1'h0
    && status_o.rsvd12 == 2'h0 && status_o.rsvd3 == 2'h0)
    else $error("reserved bits not zero");
  a_pulse_once: assert property (cmd_vld_o |=> !cmd_vld_o)
    else $error("command pulse too long");
  a_pulse_cause: assert property (cmd_vld_o |-> $past(xfer_stop_i)
    && !status_o.cmd_err && !(cmd_o.has_data && status_o.crc_err))
    else $error("command pulse without clean stop");
  a_heater_copy: assert property ($past(rst_n_i)
    |-> status_o.heater == $past(heater_on_i))
    else $error("heater bit wrong");
  a_reset_sticky: assert property ($fell(status_o.reset)
    |-> $past(xfer_stop_i)) else $error("reset flag lost");
  a_alert_sticky: assert property ($fell(status_o.alert)
    |-> $past(xfer_stop_i) && !$past(alert_pend_i))
    else $error("alert flag lost");
  a_reset_value: assert property ($rose(rst_n_i)
    |-> status_o == 16'h8010 && !cmd_vld_o)
    else $error("status wrong after reset");
endmodule : ssr_status_chk

bind ssr_status ssr_status_chk u_chk (
  .clk_sys_i, .rst_n_i, .xfer_stop_i, .alert_pend_i, .track_alert_i,
  .soft_reset_i, .supply_fail_i, .heater_on_i, .status_o, .cmd_vld_o,
  .cmd_o
);

//--- tb/ssr_host_model.sv
// Bus controller model that sends write transfers to the status block
`timescale 1ns/1ps
module ssr_host_model (
  input  wire logic       clk_sys_i,   // System clock
  output logic            start_o,     // Write header taken
  output logic            byte_vld_o,  // Write byte strobe
  output logic      [7:0] byte_o,      // Write byte
  output logic            stop_o       // Transfer end
);
  int unsigned gap = 0;  // Idle cycles after each byte, slows the host

  // ------------------------------------------------------------
  // Idle levels
  // ------------------------------------------------------------
  initial begin
    start_o = 1'b0;
    byte_vld_o = 1'b0;
    byte_o = 8'h00;
    stop_o = 1'b0;
  end

  // Checksum over a data word, bitwise, MSB first
  function automatic logic [7:0] crc16(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ((c << 1) ^ 8'h31) : (c << 1);
    end
    return c;
  endfunction : crc16

  // Start, bytes MSB first, stop; byte lines toggle when not valid
  task automatic send(input logic [7:0] b[$]);
    @(posedge clk_sys_i) #1;
    start_o = 1'b1;
    @(posedge clk_sys_i) #1;
    start_o = 1'b0;
    foreach (b[i]) begin
      byte_vld_o = 1'b1;
      byte_o = b[i];
      @(posedge clk_sys_i) #1;
      // Strobe drops only when idle cycles really follow
      if (gap > 0) begin
        byte_vld_o = 1'b0;
        byte_o = ~byte_o;
        repeat (gap) @(posedge clk_sys_i) #1;
      end
    end
    byte_vld_o = 1'b0;
    byte_o = ~byte_o;
    stop_o = 1'b1;
    @(posedge clk_sys_i) #1;
    stop_o = 1'b0;
  endtask : send
endmodule : ssr_host_model

//--- tb/tb_ssr_status.sv
// Self-checking bench for the sensor status word block
`timescale 1ns/1ps
module tb_ssr_status;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] st;  // Status word
    logic        v;   // Command pulse
    logic [32:0] c;   // Command word
  } ssr_note_t;
  logic                 clk_sys_i;       // System clock
  logic                 rst_n_i;         // Reset, active low
  logic                 xfer_start_i;    // Transfer start
  logic                 byte_vld_i;      // Byte strobe
  logic [7:0]           byte_i;          // Byte
  logic                 xfer_stop_i;     // Transfer end
  logic                 cmd_known_i;     // Decoder verdict
  logic                 alert_pend_i;    // Alert pending
  logic [2:0]           ev;              // Track, soft reset, supply
  logic                 heater_on_i;     // Heater state
  ssr_pkg::ssr_status_t status_o;        // Status word
  logic                 cmd_vld_o;       // Command pulse
  ssr_pkg::ssr_cmd_t    cmd_o;           // Command word
  ssr_note_t            exp_q[$];        // Expected results
  ssr_note_t            nt;              // Note being built
  ssr_note_t            mn;              // Note being checked
  logic                 stop_q = 1'b0;   // Stop seen last edge
  logic                 al, ht, tr, rs;  // Expected flags
  logic                 ce, cr;          // Expected error bits
  logic [15:0]          w;               // Random data word
  logic [7:0]           c;               // Checksum sent
  int                   n_errors;        // Mismatches
  int                   comparisons;     // Compares made

  ssr_host_model host (.clk_sys_i, .start_o(xfer_start_i),
    .byte_vld_o(byte_vld_i), .byte_o(byte_i), .stop_o(xfer_stop_i));
  ssr_status dut (.clk_sys_i, .rst_n_i, .xfer_start_i, .byte_vld_i,
    .byte_i, .xfer_stop_i, .cmd_known_i, .alert_pend_i,
    .track_alert_i(ev[0]), .soft_reset_i(ev[1]), .supply_fail_i(ev[2]),
    .heater_on_i, .status_o, .cmd_vld_o, .cmd_o);

  // Clock, 100 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic chk_st(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL status_o expected %h seen %h", e, g);
    end
  endtask : chk_st

  // Command word is only meaningful with the pulse
  task automatic chk_cmd(input logic [33:0] e, input logic [33:0] g);
    comparisons++;
    if (g[33] !== e[33] || (e[33] && g !== e)) begin
      n_errors++;
      $display("FAIL cmd_vld_o/cmd_o expected %h seen %h", e, g);
    end
  endtask : chk_cmd

  task automatic summarize();
    // Notes never checked count against the run
    if (exp_q.size() > 0) begin
      n_errors++;
    end
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // Oldest note is checked one edge after the stop was taken
  always @(posedge clk_sys_i) begin
    if (stop_q === 1'b1 && exp_q.size() > 0) begin
      mn = exp_q.pop_front();
      chk_st(mn.st, status_o);
      chk_cmd({mn.v, mn.c}, {cmd_vld_o, cmd_o});
    end
    stop_q <= xfer_stop_i;
  end

  // ------------------------------------------------------------
  // Stimulus tasks
  // ------------------------------------------------------------
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    #1 chk_st(16'h8010, status_o);
    rst_n_i = 1'b1;
    {al, ht, tr, rs, ce, cr} = 6'b100100;
  endtask : do_reset

  // Pulse track (0), soft reset (1) or supply failure (2)
  task automatic pulse_ev(input int k);
    @(posedge clk_sys_i) #1 ev = 3'(1 << k);
    @(posedge clk_sys_i) #1 ev = 3'h0;
    tr = tr | (k == 0);
    rs = rs | (k != 0);
  endtask : pulse_ev

  // Note the expected outcome, then send the transfer
  task automatic run(input logic [7:0] b[$], input logic known);
    logic [15:0] code;
    logic [15:0] data;
    logic        ok;
    code = {b[0], b[1]};
    data = (b.size() > 3) ? {b[2], b[3]} : 16'h0000;
    heater_on_i = 1'($urandom);
    ht = heater_on_i;
    cmd_known_i = known;
    nt = '0;
    al = al | alert_pend_i;
    if (b.size() == 2 && code == 16'h3041) begin
      al = alert_pend_i;
      {tr, rs, ce} = 3'b000;
    end else if (b.size() == 2) begin
      ce = ~known;
      nt.v = known;
      nt.c = {code, 1'b0, 16'h0000};
    end else if (b.size() == 5) begin
      ok = host.crc16(data) === b[4];
      cr = ~ok;
      ce = ~(ok & known);
      nt.v = ok & known;
      nt.c = {code, 1'b1, data};
    end else begin
      ce = 1'b1;
    end
    nt.st = {al, 1'b0, ht, 2'h0, tr, 5'h00, rs, 2'h0, ce, cr};
    exp_q.push_back(nt);
    host.send(b);
  endtask : run

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    cmd_known_i = 1'b0;
    alert_pend_i = 1'b0;
    ev = 3'h0;
    heater_on_i = 1'b0;
    n_errors = 0;
    comparisons = 0;
    void'($urandom(32'h7206));
    do_reset();
    run('{8'h30, 8'h41}, 1'b0);
    for (int k = 0; k < 3; k++) begin
      pulse_ev(k);
      run('{8'h12, 8'h34}, 1'b0);
      run('{8'h30, 8'h41}, 1'b0);
    end
    alert_pend_i = 1'b1;
    run('{8'h30, 8'h41}, 1'b1);
    alert_pend_i = 1'b0;
    run('{8'h30, 8'h41}, 1'b0);
    run('{8'h30, 8'h41, 8'hbe, 8'hef, 8'h92}, 1'b1);
    for (int i = 0; i < 12; i++) begin
      w = 16'($urandom);
      host.gap = $urandom_range(2);
      c = host.crc16(w) ^ 8'((i % 3) == 0);
      run('{8'h30, 8'($urandom), w[15:8], w[7:0], c}, i[0]);
    end
    run('{8'h30, 8'h41, 8'hbe, 8'hef, 8'h93}, 1'b1);
    run('{8'h12, 8'h34}, 1'b1);
    run('{8'h30, 8'h41, 8'h00}, 1'b1);
    run('{8'h30, 8'h41, 8'h01, 8'h02, 8'h03, 8'h04}, 1'b1);
    do_reset();
    run('{8'h30, 8'h41}, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    summarize();
  end

  // Run needs about 300 cycles; cut a hang at 5000
  initial begin
    #50000;
    n_errors++;
    summarize();
  end
endmodule : tb_ssr_status
